// ---- logic/flash_program_erase_sequencer.sv ----
`timescale 1ns/1ps
module flash_program_erase_sequencer
  import flash_seq_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [16:0]       awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [16:0]       araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output ctrl_t                  ctrl_q,
  output logic                   pump_clk_en_q,
  output logic [ADDR_W-1:0]      erase_lo_q,
  output logic [ADDR_W-1:0]      erase_hi_q,
  output logic                   prog_wr_q,
  output logic [ADDR_W-1:0]      prog_addr_q,
  output logic [7:0]             prog_data_q,
  output logic [ADDR_W-1:0]      page_base_q,
  output logic [7:0]             page_mask_q,
  output logic                   arr_rd_q,
  output logic [ADDR_W-1:0]      arr_addr_q,
  input  wire logic [7:0]        arr_rdata
);
  logic              aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [16:0]       aw_addr_q;
  logic [31:0]       w_data_q, rdata_q, wdog_q;
  logic [1:0]        bresp_q, rresp_q, div_cnt_q, div_mask;
  logic [3:0]        stretch_q;
  logic              wr_fire, wr_arr, margin_rd_q, wstrb_q0;
  logic [ADDR_W-1:0] w_idx;
  rd_state_t         rd_st_q;
  ctrl_t             wc, nc;

  assign awready = ~aw_have_q & ~bvalid_q;
  assign wready  = ~w_have_q & ~bvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = (rd_st_q == R_IDLE);
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  assign wr_arr  = wr_fire & arr_hit(aw_addr_q);
  assign w_idx   = aw_addr_q[15:2];
  assign wc      = w_data_q[7:0];

  // write channels taken in either order, answered once both are held
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      aw_addr_q <= 17'h00000;
      w_data_q  <= 32'h00000000;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (arr_hit(aw_addr_q) || aw_addr_q == CTRL_OFS || aw_addr_q == WDOG_OFS
                      || aw_addr_q == STAT_OFS) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // control bits with their interlocks; status register is read-only
  always_comb begin
    nc            = wc;
    nc.prog       = wc.prog & ~wc.erase & ~ctrl_q.erase;
    nc.erase      = wc.erase & ~wc.prog & ~ctrl_q.prog;
    nc.hv         = wc.hv & (ctrl_q.prog | ctrl_q.erase) & (nc.prog | nc.erase);
    nc.margin     = wc.margin & ~nc.hv;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= ctrl_t'(CTRL_RST);
    end else if (wr_fire && aw_addr_q == CTRL_OFS && wstrb_q0) begin
      ctrl_q <= nc;
    end
  end

  // byte lane 0 carries every control bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wstrb_q0 <= 1'b0;
    end else if (wvalid && wready) begin
      wstrb_q0 <= wstrb[0];
    end
  end

  // pump enable pulse; counter runs even with high voltage off
  always_comb begin
    case (ctrl_q.pump_div)
      2'b00:   div_mask = 2'b00;
      2'b11:   div_mask = 2'b11;
      default: div_mask = 2'b01;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt_q     <= 2'b00;
      pump_clk_en_q <= 1'b0;
    end else begin
      div_cnt_q     <= (div_cnt_q + 2'b01) & div_mask;
      pump_clk_en_q <= (div_cnt_q == 2'b00);
    end
  end

  // erase extent latched from the one write into the block
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      erase_lo_q <= 14'h0000;
      erase_hi_q <= 14'h0000;
    end else if (wr_arr && ctrl_q.erase && !ctrl_q.hv) begin
      {erase_lo_q, erase_hi_q} <= erase_span(ctrl_q.erase_size, w_idx);
    end
  end

  // program latches; a write to another page starts a fresh byte mask
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prog_wr_q   <= 1'b0;
      prog_addr_q <= 14'h0000;
      prog_data_q <= 8'h00;
      page_base_q <= 14'h0000;
      page_mask_q <= 8'h00;
    end else begin
      prog_wr_q <= 1'b0;
      if (wr_arr && ctrl_q.prog && !ctrl_q.hv) begin
        prog_wr_q   <= 1'b1;
        prog_addr_q <= w_idx;
        prog_data_q <= w_data_q[7:0];
        page_base_q <= {w_idx[13:3], 3'b000};
        page_mask_q <= ((w_idx[13:3] == page_base_q[13:3]) ? page_mask_q : 8'h00) | (8'h01 << w_idx[2:0]);
      end
    end
  end

  // free-running watchdog, also through stretched reads; a write to WDOG_OFS clears it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wdog_q <= 32'h00000000;
    end else if (wr_fire && aw_addr_q == WDOG_OFS) begin
      wdog_q <= 32'h00000000;
    end else begin
      wdog_q <= wdog_q + 32'h00000001;
    end
  end

  // read path: array reads wait one cycle, margin reads eight more
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_st_q     <= R_IDLE;
      rvalid_q    <= 1'b0;
      rdata_q     <= 32'h00000000;
      rresp_q     <= RESP_OKAY;
      arr_rd_q    <= 1'b0;
      arr_addr_q  <= 14'h0000;
      stretch_q   <= 4'h0;
      margin_rd_q <= 1'b0;
    end else begin
      arr_rd_q <= 1'b0;
      case (rd_st_q)
        R_IDLE: begin
          if (arvalid) begin
            rresp_q <= RESP_OKAY;
            if (arr_hit(araddr)) begin
              arr_rd_q    <= 1'b1;
              arr_addr_q  <= araddr[15:2];
              margin_rd_q <= ctrl_q.margin;
              stretch_q   <= ctrl_q.margin ? MARGIN_CNT : NORMAL_CNT;
              rd_st_q     <= R_WAIT;
            end else begin
              rvalid_q <= 1'b1;
              rd_st_q  <= R_RESP;
              case (araddr)
                CTRL_OFS: rdata_q <= {24'h000000, ctrl_q};
                WDOG_OFS: rdata_q <= wdog_q;
                STAT_OFS: rdata_q <= {2'b00, page_base_q, page_mask_q, 8'h00};
                default: begin
                  rdata_q <= 32'h00000000;
                  rresp_q <= RESP_SLVERR;
                end
              endcase
            end
          end
        end
        R_WAIT: begin
          if (stretch_q == NORMAL_CNT) begin
            rdata_q  <= {24'h000000, arr_rdata};
            rvalid_q <= 1'b1;
            rd_st_q  <= R_RESP;
          end else begin
            stretch_q <= stretch_q - 4'h1;
          end
        end
        R_RESP: begin
          if (rready) begin
            rvalid_q <= 1'b0;
            rd_st_q  <= R_IDLE;
          end
        end
        default: rd_st_q <= R_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_size_decode: assert property (wr_arr && ctrl_q.erase && !ctrl_q.hv |=>
    {erase_lo_q, erase_hi_q} == erase_span($past(ctrl_q.erase_size), $past(w_idx)))
    else $error("erase extent does not match size field");
  a_pump_div4: assert property ((ctrl_q.pump_div == 2'b11) [*4] ##0 pump_clk_en_q
    ##1 (ctrl_q.pump_div == 2'b11) [*3] |-> $past(!pump_clk_en_q, 2) && $past(!pump_clk_en_q))
    else $error("pump enable faster than divide by four");
  a_pump_div1: assert property ((ctrl_q.pump_div == 2'b00) [*3] |-> pump_clk_en_q)
    else $error("pump enable missing at divide by one");
  a_page_align: assert property (prog_wr_q |-> page_base_q[2:0] == 3'b000
    && page_base_q[13:3] == prog_addr_q[13:3]) else $error("page base not aligned to the byte");
  a_margin_stretch: assert property ($rose(arr_rd_q) && margin_rd_q
    |-> !rvalid_q [*8] ##1 !rvalid_q ##1 rvalid_q) else $error("margin read not stretched by eight");
  a_normal_read: assert property ($rose(arr_rd_q) && !margin_rd_q |=> rvalid_q)
    else $error("normal array read late");
  a_wdog_runs: assert property (rd_st_q == R_WAIT && !wr_fire |=> wdog_q == $past(wdog_q) + 32'h1)
    else $error("watchdog stalled during read");
  a_prog_latch: assert property (wr_arr && ctrl_q.prog && !ctrl_q.hv |=> prog_wr_q
    && prog_data_q == $past(w_data_q[7:0]) && prog_addr_q == $past(w_idx)) else $error("program write not latched");
  a_hv_mode: assert property ($rose(ctrl_q.hv) |-> $past(ctrl_q.prog || ctrl_q.erase))
    else $error("high voltage set without a mode");
  a_mode_lock: assert property (!(ctrl_q.prog && ctrl_q.erase))
    else $error("program and erase both set");
  a_margin_hv: assert property (!(ctrl_q.margin && ctrl_q.hv))
    else $error("margin set with high voltage on");

  c_margin_read: cover property ($rose(arr_rd_q) && margin_rd_q ##9 rvalid_q);
  c_erase_latch: cover property (wr_arr && ctrl_q.erase);
  c_hv_on: cover property ($rose(ctrl_q.hv) && ctrl_q.prog);
endmodule : flash_program_erase_sequencer

// ---- logic/flash_seq_pkg.sv ----
package flash_seq_pkg;
  localparam logic [16:0] CTRL_OFS  = 17'h00000;
  localparam logic [16:0] WDOG_OFS  = 17'h00004;
  localparam logic [16:0] STAT_OFS  = 17'h00008;
  localparam int          ADDR_W    = 14;
  localparam logic [ADDR_W-1:0] ARR_LAST  = 14'h2fff;
  localparam logic [ADDR_W-1:0] HALF_LAST = 14'h17ff;
  localparam logic [ADDR_W-1:0] HALF_FRST = 14'h1800;
  localparam logic [3:0]  MARGIN_CNT = 4'h9;
  localparam logic [3:0]  NORMAL_CNT = 4'h1;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [1:0] pump_div;
    logic [1:0] erase_size;
    logic       hv;
    logic       margin;
    logic       erase;
    logic       prog;
  } ctrl_t;

  typedef enum logic [1:0] {
    R_IDLE = 2'b00,
    R_WAIT = 2'b01,
    R_RESP = 2'b10
  } rd_state_t;

  // array window: bit 16 set, one flash byte per word
  function automatic logic arr_hit(input logic [16:0] a);
    arr_hit = a[16] && (a[1:0] == 2'b00) && (a[15:2] <= ARR_LAST);
  endfunction : arr_hit

  // {first, last} byte of the erase extent
  function automatic logic [2*ADDR_W-1:0] erase_span(input logic [1:0] sz, input logic [ADDR_W-1:0] a);
    case (sz)
      2'b00:   erase_span = {14'h0000, ARR_LAST};
      2'b01:   erase_span = (a <= HALF_LAST) ? {14'h0000, HALF_LAST} : {HALF_FRST, ARR_LAST};
      2'b10:   erase_span = {a[13:8], 8'h00, a[13:8], 8'hff};
      default: erase_span = {a[13:5], 5'h00, a[13:5], 5'h1f};
    endcase
  endfunction : erase_span
endpackage : flash_seq_pkg

// ---- verif/flash_array_model.sv ----
`timescale 1ns/1ps
module flash_array_model
  import flash_seq_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              prog_wr_q,
  input  wire logic [ADDR_W-1:0] prog_addr_q,
  input  wire logic [7:0]        prog_data_q,
  input  wire logic              arr_rd_q,
  input  wire logic [ADDR_W-1:0] arr_addr_q,
  output logic [7:0]             arr_rdata
);
  logic [7:0] cells [0:12287];

  initial begin
    foreach (cells[i]) cells[i] = 8'hff;
  end

  // read answers at once: a normal read is sampled on the edge that sees the strobe
  assign arr_rdata = cells[arr_addr_q];

  // programming only clears bits, as a real cell does
  always @(posedge clk_sys) begin
    if (prog_wr_q) begin
      cells[prog_addr_q] <= cells[prog_addr_q] & prog_data_q;
    end
  end
endmodule : flash_array_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import flash_seq_pkg::*;
  logic              clk_sys, rst, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, pump_clk_en_q, prog_wr_q, arr_rd_q;
  logic [16:0]       awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  ctrl_t             ctrl_q;
  logic [ADDR_W-1:0] erase_lo_q, erase_hi_q, prog_addr_q, page_base_q, arr_addr_q;
  logic [7:0]        prog_data_q, page_mask_q, arr_rdata;
  int                err_count = 0;
  int                checks_done = 0;
  int                nwr = 0;

  flash_program_erase_sequencer flash_program_erase_sequencer_inst (.clk_sys, .rst, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .ctrl_q, .pump_clk_en_q, .erase_lo_q, .erase_hi_q, .prog_wr_q,
    .prog_addr_q, .prog_data_q, .page_base_q, .page_mask_q, .arr_rd_q, .arr_addr_q, .arr_rdata);
  flash_array_model flash_array_model_inst (.clk_sys, .prog_wr_q, .prog_addr_q, .prog_data_q,
    .arr_rd_q, .arr_addr_q, .arr_rdata);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (prog_wr_q === 1'b1) nwr <= nwr + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [16:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk_sys); while (!bvalid);
    r = bresp;
  endtask : wr

  task automatic rd(input logic [16:0] a, output logic [31:0] d, output logic [1:0] r, output int n);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : rd

  task automatic wc(input logic [7:0] v, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wr(CTRL_OFS, {24'h0, v}, r);
    chk(32'(r), 32'(RESP_OKAY));
    rd(CTRL_OFS, d, r, n);
    chk(d, {24'h0, e});
  endtask : wc

  task automatic t_locks;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wc(8'h00, 8'(CTRL_RST));
    wc(8'h08, 8'h00);
    wr(CTRL_OFS, 32'h3, r);
    rd(CTRL_OFS, d, r, n);
    chk(32'(d[1] & d[0]), 32'h0);
    wc(8'h01, 8'h01);
    wc(8'h09, 8'h09);
    wc(8'h0d, 8'h09);
    wc(8'h00, 8'h00);
  endtask : t_locks

  task automatic t_pump;
    int         cnt;
    logic [2:0] dv [4] = '{3'd1, 3'd2, 3'd2, 3'd4};
    for (int c = 0; c < 4; c++) begin
      wc({2'(c), 6'h00}, {2'(c), 6'h00});
      repeat (4) @(posedge clk_sys);
      cnt = 0;
      repeat (16) begin
        @(posedge clk_sys);
        cnt += 32'(pump_clk_en_q);
      end
      chk(32'(cnt), 32'(16 / dv[c]));
    end
  endtask : t_pump

  task automatic t_erase;
    logic [13:0] lo [4] = '{14'h0000, 14'h1800, 14'h1900, 14'h1920};
    logic [13:0] hi [4] = '{14'h2fff, 14'h2fff, 14'h19ff, 14'h193f};
    logic [1:0]  r;
    for (int s = 0; s < 4; s++) begin
      wc({2'b00, 2'(s), 4'h2}, {2'b00, 2'(s), 4'h2});
      wr(17'h1648c, 32'h0, r); // byte 0x1923
      chk(32'(erase_lo_q), 32'(lo[s]));
      chk(32'(erase_hi_q), 32'(hi[s]));
    end
    wc(8'h3a, 8'h3a);
    wr(WDOG_OFS, 32'h0, r);
    wc(8'h32, 8'h32);
    wc(8'h00, 8'h00);
  endtask : t_erase

  task automatic t_prog;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    int          n0;
    wc(8'h01, 8'h01);
    chk(32'(ctrl_q.pump_div), 32'h0);
    rd(STAT_OFS, d, r, n);
    n0 = nwr;
    for (int i = 0; i < 8; i++) begin
      wr({1'b1, 14'(14'h00a8 + i), 2'b00}, {24'h0, 8'(8'h30 + i)}, r);
      chk(32'(prog_addr_q), 32'(14'h00a8 + i));
      chk(32'(prog_data_q), 32'(8'h30 + i));
    end
    // let the strobe counter take the last pulse
    @(posedge clk_sys);
    chk(32'(nwr - n0), 32'h8);
    chk(32'({page_base_q, page_mask_q}), 32'({14'h00a8, 8'hff}));
    rd(STAT_OFS, d, r, n);
    chk(d, {2'b00, 14'h00a8, 8'hff, 8'h00});
    wc(8'h09, 8'h09);
    wc(8'h01, 8'h01);
    wc(8'h05, 8'h05);
    wc(8'h04, 8'h04);
    wr(WDOG_OFS, 32'h0, r);
    for (int i = 0; i < 8; i++) begin
      rd({1'b1, 14'(14'h00a8 + i), 2'b00}, d, r, n);
      chk(d, {24'h0, 8'(8'h30 + i)});
      chk(32'(n), 32'd10);
    end
    chk(32'(arr_addr_q), 32'h00af);
    rd(WDOG_OFS, d, r, n);
    chk(32'(d >= 32'd88), 32'h1);
    wc(8'h00, 8'h00);
    repeat (500) rd(17'h10000, d, r, n);
    rd(17'h10000, d, r, n);
    chk(32'(n), 32'd2);
    chk(d, 32'hff);
  endtask : t_prog

  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wr(17'h0000c, 32'h1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(17'h0000c, d, r, n);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(d, 32'h0);
  endtask : t_unmapped

  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // whole run is a few thousand cycles; this is ample
  initial begin
    #100us;
    err_count++;
    final_report;
  end

  initial begin
    rst <= 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    awaddr <= 17'h00000;
    araddr <= 17'h00000;
    wdata <= 32'h0;
    wstrb <= 4'hf;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_locks;
    t_pump;
    t_erase;
    t_prog;
    t_unmapped;
    final_report;
  end
endmodule : tb_top
